// >>> hw/sync_loss_pkg.sv
// Package: sub-addresses, field positions, reset values and counts for the sync-loss/ID register bank
package sync_loss_pkg;
    // ************************************************************
    // Register sub-addresses
    // ************************************************************
    localparam logic [7:0] ADDR_RESERVED_A   = 8'h18;
    localparam logic [7:0] ADDR_SYNC_LOSS    = 8'h19;
    localparam logic [7:0] ADDR_RESERVED_B   = 8'h1A;
    localparam logic [7:0] ADDR_PART_ID      = 8'h1B;
    localparam logic [7:0] ADDR_SOFT_RESET   = 8'h17;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int         FAST_LOSS_BIT     = 5;
    localparam int         SOFT_RESET_BIT    = 7;
    localparam logic [7:0] RESERVED_VALUE    = 8'h00;
    localparam logic       FAST_LOSS_RESET   = 1'b0;
    localparam logic [7:0] PART_ID_DEFAULT   = 8'hA5;   // Arbitrary neutral value

    // ************************************************************
    // Counts and converter codes
    // ************************************************************
    localparam logic [3:0] SLOW_LOSS_MISSES  = 4'hC;    // 12 missed syncs
    localparam logic [3:0] FAST_LOSS_MISSES  = 4'h1;
    localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;
    localparam logic [7:0] WHITE_PEAK_CODE   = 8'hF8;   // 248
    localparam logic [7:0] FULL_SCALE_CODE   = 8'hFF;   // 255
endpackage

// >>> hw/sync_loss_regs.sv
// Sync-loss control, reserved bytes, part identification and white-peak limiting
`timescale 1ns/10ps

module sync_loss_regs #(
    parameter logic [7:0] PART_ID = sync_loss_pkg::PART_ID_DEFAULT  // Arbitrary value
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Register access from the serial host side
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    // Line-lock loop events
    input  wire logic       hsync_expected_in,
    input  wire logic       hsync_found_in,
    input  wire logic       lock_acquired_in,
    // White-peak pin and converter code
    input  wire logic       white_peak_limit_enable_in,
    input  wire logic [7:0] adc_code_in,
    // Outputs, each taken from the registered state
    output logic [7:0]      reg_rdata_out,
    output logic            fast_loss_select_out,
    output logic            tracking_out,
    output logic            lock_lost_out,
    output logic            gain_reduce_out,
    output logic            adc_clip_out,
    output logic            soft_reset_out
);
    // ************************************************************
    // State
    // ************************************************************
    // One-hot loop codes; the all-zero code is illegal and falls back to acquisition
    typedef enum logic [1:0] {
        ACQUIRE = 2'b01,
        TRACK   = 2'b10
    } loop_state_t;

    // Whole module state in one packed record
    typedef struct packed {
        logic [7:0]  rdata;
        logic        fast_loss;
        loop_state_t loop;
        logic [3:0]  misses;
        logic        lost;
        logic        gain_reduce;
        logic        clip;
        logic [2:0]  soft_cnt;
        logic        soft_active;
    } regs_state_t;

    // Registered state and its next value
    regs_state_t state_q;
    regs_state_t state_d;
    logic        wpe_sync;

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    // Pin is asynchronous to the master clock
    sync_sampler wpe_sampler (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (white_peak_limit_enable_in),
        .level_out (wpe_sync)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [3:0] limit;
        logic       miss;
        logic       soft_req;
        limit   = state_q.fast_loss ? sync_loss_pkg::FAST_LOSS_MISSES
                                    : sync_loss_pkg::SLOW_LOSS_MISSES;
        miss    = hsync_expected_in && !hsync_found_in;
        // New soft-reset request, kept apart so it can win over the countdown
        soft_req = reg_wr_in && (reg_addr_in == sync_loss_pkg::ADDR_SOFT_RESET)
                   && reg_wdata_in[sync_loss_pkg::SOFT_RESET_BIT];
        state_d = state_q;
        state_d.lost = 1'b0;

        // ************************************************************
        // Register writes
        // ************************************************************
        // Reserved and read-only sub-addresses fall through untouched
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                sync_loss_pkg::ADDR_SYNC_LOSS: begin
                    state_d.fast_loss = reg_wdata_in[sync_loss_pkg::FAST_LOSS_BIT];
                end
                sync_loss_pkg::ADDR_SOFT_RESET: begin
                    // Start is applied after the countdown below, so a late request still wins
                end
                sync_loss_pkg::ADDR_RESERVED_A,
                sync_loss_pkg::ADDR_RESERVED_B,
                sync_loss_pkg::ADDR_PART_ID: begin
                    // writes to 0x18, 0x1A, 0x1B have no effect
                end
                default: begin
                    // Unmapped sub-addresses drop the write as well
                end
            endcase
        end

        // ************************************************************
        // Read mux
        // ************************************************************
        // Holds last value between reads
        // Unmapped sub-addresses read zero
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                sync_loss_pkg::ADDR_RESERVED_A,
                sync_loss_pkg::ADDR_RESERVED_B: state_d.rdata = sync_loss_pkg::RESERVED_VALUE;
                sync_loss_pkg::ADDR_SYNC_LOSS: begin
                    state_d.rdata = '0;
                    state_d.rdata[sync_loss_pkg::FAST_LOSS_BIT] = state_q.fast_loss;
                end
                sync_loss_pkg::ADDR_PART_ID:    state_d.rdata = PART_ID;
                sync_loss_pkg::ADDR_SOFT_RESET: begin
                    state_d.rdata = '0;
                    state_d.rdata[sync_loss_pkg::SOFT_RESET_BIT] = state_q.soft_active;
                end
                default:                        state_d.rdata = '0;
            endcase
        end

        // ************************************************************
        // Line-lock loop
        // ************************************************************
        // Consecutive misses only, counted in TRACK
        // Found wins over a miss in the same cycle
        unique case (state_q.loop)
            ACQUIRE: begin
                state_d.misses = '0;
                if (lock_acquired_in) begin
                    state_d.loop = TRACK;
                end
            end
            TRACK: begin
                if (hsync_found_in) begin
                    state_d.misses = '0;
                end else if (miss) begin
                    if (state_q.misses + 4'h1 >= limit) begin
                        state_d.loop   = ACQUIRE;
                        state_d.lost   = 1'b1;
                        state_d.misses = '0;
                    end else begin
                        state_d.misses = state_q.misses + 4'h1;
                    end
                end
            end
            default: begin
                state_d.loop = ACQUIRE;
            end
        endcase

        // ************************************************************
        // White-peak limiting
        // ************************************************************
        // Gain reduction versus plain clipping
        // Decision lags the code by one cycle, the pin by two more
        state_d.gain_reduce = wpe_sync && (adc_code_in > sync_loss_pkg::WHITE_PEAK_CODE);
        state_d.clip        = !wpe_sync && (adc_code_in == sync_loss_pkg::FULL_SCALE_CODE);

        // ************************************************************
        // Software reset
        // ************************************************************
        // Restore registers, keep bus side, self-clear after 4 clocks
        // Read data is left alone: the bus side stays outside its reach
        if (state_q.soft_active) begin
            state_d.fast_loss = sync_loss_pkg::FAST_LOSS_RESET;
            state_d.loop      = ACQUIRE;
            state_d.misses    = '0;
            state_d.lost      = 1'b0;
            state_d.soft_cnt  = state_q.soft_cnt + 3'h1;
            if (state_q.soft_cnt + 3'h1 == sync_loss_pkg::SOFT_RESET_CYCLES) begin
                state_d.soft_active = 1'b0;
            end
        end

        // Fresh request restarts the count; set wins over the self-clear
        if (soft_req) begin
            state_d.soft_active = 1'b1;
            state_d.soft_cnt    = '0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset pin loads every register; async pin assumed synchronised upstream
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q           <= '0;
            state_q.fast_loss <= sync_loss_pkg::FAST_LOSS_RESET;
            state_q.loop      <= ACQUIRE;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs, all registered
    // ************************************************************
    // Read data holds until the next read
    assign reg_rdata_out        = state_q.rdata;
    assign fast_loss_select_out = state_q.fast_loss;
    assign tracking_out         = (state_q.loop == TRACK);
    assign lock_lost_out        = state_q.lost;
    assign gain_reduce_out      = state_q.gain_reduce;
    assign adc_clip_out         = state_q.clip;
    assign soft_reset_out       = state_q.soft_active;
endmodule

// >>> hw/sync_sampler.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync_sampler (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic first;
        logic second;
    } sampler_state_t;

    sampler_state_t state_q;
    sampler_state_t state_d;

    // First stage feeds only the second stage
    always_comb begin
        state_d.first  = pin_in;
        state_d.second = state_q.first;
    end

    // Register the stages
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign level_out = state_q.second;
endmodule

// >>> sim/reg_host.sv
// Host model: one-cycle register read and write strobes
`timescale 1ns/10ps
module reg_host (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic            wr_out = 1'b0,
    output logic            rd_out = 1'b0,
    output logic [7:0]      addr_out = 8'h00,
    output logic [7:0]      wdata_out = 8'h00
);
    // Released lines show inverted values, never the stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in) {wr_out, addr_out, wdata_out} <= {1'b1, a, d};
        @(posedge clk_in) {wr_out, addr_out, wdata_out} <= {1'b0, ~a, ~d};
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in) {rd_out, addr_out} <= {1'b1, a};
        @(posedge clk_in) {rd_out, addr_out} <= {1'b0, ~a};
        #1 d = rdata_in;
    endtask
endmodule

// >>> sim/sync_loss_regs_assertions.sv
// Checker: port-level properties of the sync-loss register bank
`timescale 1ns/10ps
module sync_loss_regs_assertions #(
    parameter logic [7:0] PART_ID = 8'hA5  // Arbitrary value
) (
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       fast_loss_select_out,
    input wire logic       soft_reset_out,
    input wire logic       tracking_out,
    input wire logic       lock_lost_out,
    input wire logic       hsync_expected_in,
    input wire logic       hsync_found_in
);
    // One domain; the pin reset masks all but the reset check
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_rsv; reg_rd_in && reg_addr_in inside {8'h18, 8'h1A} |=> reg_rdata_out == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved byte not zero");
    property p_id; reg_rd_in && reg_addr_in == 8'h1B |=> reg_rdata_out == PART_ID; endproperty
    a_id: assert property (p_id) else $error("part code wrong");
    property p_ctl; reg_rd_in && reg_addr_in == 8'h19 |=> reg_rdata_out == {2'h0, $past(fast_loss_select_out), 5'h00}; endproperty
    a_ctl: assert property (p_ctl) else $error("control byte readback wrong");
    property p_srst; $rose(soft_reset_out) |-> soft_reset_out [*4] ##1 !soft_reset_out; endproperty
    a_srst: assert property (p_srst) else $error("soft reset length wrong");
    property p_sclr; soft_reset_out |=> !fast_loss_select_out; endproperty
    a_sclr: assert property (p_sclr) else $error("select kept in soft reset");
    property p_rst; disable iff (1'b0) !rst_n_in |=> !fast_loss_select_out && !tracking_out && !soft_reset_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_loss; lock_lost_out |-> !tracking_out && $past(tracking_out); endproperty
    a_loss: assert property (p_loss) else $error("loss without leaving track");
    // Soft reset excluded: it clears the loop on its own
    property p_fast; tracking_out && fast_loss_select_out && !soft_reset_out
        && hsync_expected_in && !hsync_found_in |=> lock_lost_out; endproperty
    a_fast: assert property (p_fast) else $error("fast loss missed");
    c_lost: cover property (lock_lost_out);
    c_srst: cover property ($rose(soft_reset_out));
    c_fast: cover property (fast_loss_select_out && lock_lost_out);
endmodule
bind sync_loss_regs sync_loss_regs_assertions #(.PART_ID(PART_ID)) i_sync_loss_regs_assertions (.*);

// >>> sim/tb_sync_loss_regs.sv
// Self-checking bench for the sync-loss register bank
`timescale 1ns/10ps
module tb_sync_loss_regs;
    logic       clk_in = 1'b0, rst_n_in = 1'b0, wr, rd, hexp = 1'b0, hfnd = 1'b0, lk = 1'b0, pin = 1'b0;
    logic       fsel, trk, lost, gain, clip, srst;
    logic [7:0] addr, wdata, rdata, v, code = 8'h00;
    int         err_total = 0, num_checks = 0;
    reg_host i_reg_host (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr),
        .wdata_out(wdata));
    sync_loss_regs i_sync_loss_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .hsync_expected_in(hexp), .hsync_found_in(hfnd),
        .lock_acquired_in(lk), .white_peak_limit_enable_in(pin), .adc_code_in(code), .reg_rdata_out(rdata),
        .fast_loss_select_out(fsel), .tracking_out(trk), .lock_lost_out(lost), .gain_reduce_out(gain),
        .adc_clip_out(clip), .soft_reset_out(srst));
    // 25 MHz clock
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        i_reg_host.wr(a, d);
        i_reg_host.rd(a, v);
        chk(v, exp);
    endtask
    // Misses spaced one idle cycle apart
    task automatic miss(input int n);
        repeat (n) begin
            @(posedge clk_in) hexp <= 1'b1;
            @(posedge clk_in) hexp <= 1'b0;
        end
        #1;
    endtask
    task automatic t_regs();
        i_reg_host.rd(8'h19, v);
        chk(v, 8'h00);
        wrrd(8'h18, 8'hFF, 8'h00);
        wrrd(8'h1A, 8'hFF, 8'h00);
        wrrd(8'h1B, 8'h00, sync_loss_pkg::PART_ID_DEFAULT);
        wrrd(8'h19, 8'hFF, 8'h20);
        wrrd(8'h19, 8'hDF, 8'h00);
    endtask
    // A found sync mid-way must restart the count
    task automatic t_loss(input logic f, input int n);
        i_reg_host.wr(8'h19, {2'h0, f, 5'h00});
        @(posedge clk_in) lk <= 1'b1;
        @(posedge clk_in) lk <= 1'b0;
        miss(n - 1);
        chkb(trk, 1'b1);
        @(posedge clk_in) {hexp, hfnd} <= 2'b11;
        @(posedge clk_in) {hexp, hfnd} <= 2'b00;
        miss(n - 1);
        chkb(trk, 1'b1);
        miss(1);
        chkb(lost, 1'b1);
        chkb(trk, 1'b0);
    endtask
    task automatic t_soft();
        i_reg_host.wr(8'h19, 8'h20);
        i_reg_host.wr(8'h17, 8'h80);
        chkb(srst, 1'b1);
        // Readback while active shows the request bit, then two more edges end it
        i_reg_host.rd(8'h17, v);
        chk(v, 8'h80);
        chkb(srst, 1'b1);
        repeat (2) @(posedge clk_in);
        #1 chkb(srst, 1'b0);
        chkb(fsel, 1'b0);
        i_reg_host.wr(8'h19, 8'h20);
        @(posedge clk_in) rst_n_in <= 1'b0;
        @(posedge clk_in) rst_n_in <= 1'b1;
        #1 chkb(fsel, 1'b0);
    endtask
    // Pin passes a two-flop chain, so allow four edges
    task automatic t_peak();
        @(posedge clk_in) {pin, code} <= {1'b1, 8'hF9};
        repeat (4) @(posedge clk_in);
        #1 chkb(gain, 1'b1);
        @(posedge clk_in) code <= 8'hF8;
        repeat (2) @(posedge clk_in);
        #1 chkb(gain, 1'b0);
        @(posedge clk_in) {pin, code} <= {1'b0, 8'hFF};
        repeat (4) @(posedge clk_in);
        #1 chkb(clip, 1'b1);
        chkb(gain, 1'b0);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_loss(1'b0, 12);
        t_loss(1'b1, 1);
        t_soft();
        t_peak();
        stop_test();
    end
    // Watchdog, about seventeen times the expected run
    initial begin
        repeat (2000) @(posedge clk_in);
        err_total++;
        stop_test();
    end
endmodule
